// ===== shs_pkg.sv
// Purpose: constants and carrier types of the sensor heating sequencer
// Assumes: 200 MHz system clock, one-second time base
// Notes: temperatures in 0.01 degC signed, humidity in 0.01 %RH
package shs_pkg;

  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam longint CLK_HZ = 200_000_000;
  localparam int TIMEBASE_S = 1;
  localparam int TICK_CYCLES = int'(CLK_HZ * TIMEBASE_S);

  // ****************************************************************
  // sequence timing, in seconds of the time base
  // ****************************************************************
  localparam int PURGE_TOTAL_S = 360;
  localparam int PURGE_HEAT_S = 240;
  localparam int PURGE_COOL_S = PURGE_TOTAL_S - PURGE_HEAT_S;
  localparam int STARTUP_S = 10;
  localparam logic [3:0] STARTUP_GO = 4'h2;
  localparam int XCOOL_S = 30;
  localparam logic [19:0] PERIOD_MIN = 20'h0_A8C0;
  localparam logic [19:0] PERIOD_MAX = 20'hD_2F00;

  // ****************************************************************
  // register indexes
  // ****************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PURGE_CFG = 4'h1;
  localparam logic [3:0] REG_PURGE_PERIOD = 4'h2;
  localparam logic [3:0] REG_PURGE_TEMP = 4'h3;
  localparam logic [3:0] REG_XHEAT_TEMP = 4'h4;
  localparam logic [3:0] REG_XHEAT_DUR = 4'h5;
  localparam logic [3:0] REG_XHEAT_LIMIT = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_WARM_BIT = 0;
  localparam int CTRL_XHEAT_BIT = 1;
  localparam int PCFG_STARTUP_BIT = 0;
  localparam int PCFG_INTERVAL_BIT = 1;
  localparam logic [19:0] PERIOD_RST = 20'h1_5180;
  localparam logic [15:0] PURGE_TEMP_RST = 16'h4650;
  localparam logic [15:0] XHEAT_TEMP_RST = 16'h2710;
  localparam logic [15:0] XHEAT_DUR_RST = 16'h001E;
  localparam logic [15:0] XHEAT_LIMIT_RST = 16'h251C;
  localparam logic [15:0] WARM_LIMIT = 16'h1F40;
  localparam logic [15:0] RH_FULL = 16'h2710;

  // ****************************************************************
  // states and carriers
  // ****************************************************************
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PHEAT = 5'b00010,
    ST_PCOOL = 5'b00100,
    ST_XHEAT = 5'b01000,
    ST_XCOOL = 5'b10000
  } shs_state_type;

  typedef struct packed {
    logic valid;
    logic [15:0] rh;
    logic signed [15:0] dew;
    logic signed [15:0] amb;
    logic [15:0] mix;
  } shs_meas_type;

  typedef struct packed {
    logic rh_valid;
    logic [15:0] rh;
    logic signed [15:0] dew;
    logic signed [15:0] amb;
    logic [15:0] mix;
  } shs_out_type;

  typedef struct packed {
    logic probe_on;
    logic probe_boost;
    logic sens_on;
    logic [15:0] sens_setpt;
  } shs_heat_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } shs_bus_type;

  typedef struct packed {
    shs_state_type state;
    logic [27:0] tick_cnt;
    logic [19:0] sec_cnt;
    logic [19:0] intv_cnt;
    logic [3:0] boot_cnt;
    logic boot_done;
    logic purge_pend;
    logic xheat_pend;
    logic warm_en;
    logic xheat_en;
    logic su_en;
    logic iv_en;
    logic [19:0] period;
    logic [15:0] ptemp;
    logic [15:0] xtemp;
    logic [15:0] xdur;
    logic [15:0] xlim;
    logic [31:0] rdata;
    shs_out_type out;
  } shs_st_type;

endpackage

// ===== shs_heat_seq.sv
// Purpose: heating sequencer of a humidity and temperature probe
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes: registers are reached over a plain address/strobe port
//
// What this block does
// - with warming selected the probe heater runs all the time, boosted at 80 %RH when the extra probe is fitted (humidity is 0 without it).
// - warming without the extra temperature probe leaves only dew point and mixing ratio valid.
// - with the extra probe, humidity is computed from dew point and ambient temperature.
// - warming, purge and extra heating only work on a composite sensor.
// - a purge heats the sensor to a settable point, 180 degC by default, for 6 min in all.
// - interval purge repeats at a period held between half a day and ten days.
// - with startup purge on, a purge begins within 10 s of power-up.
// - a purge is a heating phase then a cooling phase, 6 min together, then normal mode.
// - outputs stay frozen through the whole purge, cooling included.
// - the purge configuration register turns startup and interval purge off or on; the period has its own register.
// - extra heating temperature, duration and humidity limit are all settable.
// - extra heating starts at the humidity limit, by default 100 degC for 30 s at 95 %RH.
// - a new extra heating cycle starts whenever the trigger is met again.
// - outputs hold the pre-cycle values through extra heating and its cooling.
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

module shs_heat_seq #(
  parameter int P_TICK_CYCLES = shs_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register port
  input wire shs_pkg::shs_bus_type i_bus,
  output shs_pkg::shs_st_type o_dbg_unused_never,
  output logic [31:0] o_rdata,
  // probe fit and stored purge settings
  input wire logic i_composite,
  input wire logic i_tprobe,
  input wire logic i_nv_startup,
  input wire logic i_nv_interval,
  output logic o_nv_startup,
  output logic o_nv_interval,
  // measurement front end
  input wire shs_pkg::shs_meas_type i_meas,
  output shs_pkg::shs_heat_type o_heat,
  // held measurement outputs
  output shs_pkg::shs_out_type o_out,
  output logic o_frozen
);

  // ****************************************************************
  // state
  // ****************************************************************
  shs_pkg::shs_st_type st_reg;
  shs_pkg::shs_st_type st_next;
  logic tick;
  logic idle;
  logic feat_ok;
  logic purge_due;
  logic xheat_due;
  logic signed [17:0] rh_calc;
  logic [15:0] rh_sel;
  logic [19:0] wper;

  // feature gate and time base strobe
  assign feat_ok = i_composite;
  assign tick = (st_reg.tick_cnt == 28'(P_TICK_CYCLES - 1));
  assign idle = (st_reg.state == shs_pkg::ST_IDLE);

  // humidity from dew point depression, 5 %RH per degC, clipped to 0..100
  always_comb begin
    rh_calc = 18'sd10000 - 18'sd5 * (18'(i_meas.amb) - 18'(i_meas.dew));
    if (rh_calc < 18'sd0) begin
      rh_calc = 18'sd0;
    end else if (rh_calc > 18'sd10000) begin
      rh_calc = 18'sd10000;
    end
  end

  // source of the humidity output
  always_comb begin
    if (i_tprobe) begin
      rh_sel = rh_calc[15:0];
    end else if (st_reg.warm_en && feat_ok) begin
      rh_sel = 16'h0000;
    end else begin
      rh_sel = i_meas.rh;
    end
  end

  // requests waiting for the sequencer
  assign purge_due = feat_ok && st_reg.iv_en && (st_reg.intv_cnt >= st_reg.period);
  assign xheat_due = feat_ok && st_reg.xheat_en && i_meas.valid &&
                     (i_meas.rh >= st_reg.xlim);

  // clamp a written period into the legal range
  always_comb begin
    wper = i_bus.wdata[19:0];
    if (i_bus.wdata[31:20] != 12'h000 || wper > shs_pkg::PERIOD_MAX) begin
      wper = shs_pkg::PERIOD_MAX;
    end else if (wper < shs_pkg::PERIOD_MIN) begin
      wper = shs_pkg::PERIOD_MIN;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;

    // free-running one-second time base
    if (tick) begin
      st_next.tick_cnt = 28'h000_0000;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 28'h000_0001;
    end

    // register writes
    if (i_bus.wr) begin
      case (i_bus.addr)
        shs_pkg::REG_CTRL: begin
          st_next.warm_en = i_bus.wdata[shs_pkg::CTRL_WARM_BIT];
          st_next.xheat_en = i_bus.wdata[shs_pkg::CTRL_XHEAT_BIT];
        end
        shs_pkg::REG_PURGE_CFG: begin
          st_next.su_en = i_bus.wdata[shs_pkg::PCFG_STARTUP_BIT];
          st_next.iv_en = i_bus.wdata[shs_pkg::PCFG_INTERVAL_BIT];
        end
        shs_pkg::REG_PURGE_PERIOD: st_next.period = wper;
        shs_pkg::REG_PURGE_TEMP: st_next.ptemp = i_bus.wdata[15:0];
        shs_pkg::REG_XHEAT_TEMP: st_next.xtemp = i_bus.wdata[15:0];
        shs_pkg::REG_XHEAT_DUR: begin
          // a zero duration is stored as one; the phase then ends on its first tick
          st_next.xdur = (i_bus.wdata[15:0] == 16'h0000) ? 16'h0001 : i_bus.wdata[15:0];
        end
        shs_pkg::REG_XHEAT_LIMIT: st_next.xlim = i_bus.wdata[15:0];
        default: begin
        end
      endcase
    end

    // register reads, answered in the following cycle
    if (i_bus.rd) begin
      case (i_bus.addr)
        shs_pkg::REG_CTRL: st_next.rdata = {30'h0000_0000, st_reg.xheat_en, st_reg.warm_en};
        shs_pkg::REG_PURGE_CFG: st_next.rdata = {30'h0000_0000, st_reg.iv_en, st_reg.su_en};
        shs_pkg::REG_PURGE_PERIOD: st_next.rdata = {12'h000, st_reg.period};
        shs_pkg::REG_PURGE_TEMP: st_next.rdata = {16'h0000, st_reg.ptemp};
        shs_pkg::REG_XHEAT_TEMP: st_next.rdata = {16'h0000, st_reg.xtemp};
        shs_pkg::REG_XHEAT_DUR: st_next.rdata = {16'h0000, st_reg.xdur};
        shs_pkg::REG_XHEAT_LIMIT: st_next.rdata = {16'h0000, st_reg.xlim};
        shs_pkg::REG_STATUS: begin
          st_next.rdata = {20'h0_0000, st_reg.out.rh_valid, i_tprobe, i_composite,
                           st_reg.xheat_pend, st_reg.purge_pend, st_reg.boot_done,
                           1'b0, st_reg.state};
        end
        default: st_next.rdata = 32'h0000_0000;
      endcase
    end

    // startup purge, raised a couple of seconds after reset release
    if (tick && !st_reg.boot_done) begin
      st_next.boot_cnt = st_reg.boot_cnt + 4'h1;
      if (st_reg.boot_cnt + 4'h1 >= shs_pkg::STARTUP_GO) begin
        st_next.boot_done = 1'b1;
        if (st_reg.su_en && feat_ok) begin
          st_next.purge_pend = 1'b1;
        end
      end
    end

    // interval timer counts seconds of normal mode since the last purge
    if (!st_reg.iv_en) begin
      st_next.intv_cnt = 20'h0_0000;
    end else if (tick && idle && !purge_due) begin
      st_next.intv_cnt = st_reg.intv_cnt + 20'h0_0001;
    end
    if (purge_due) begin
      st_next.purge_pend = 1'b1;
      st_next.intv_cnt = 20'h0_0000;
    end
    if (xheat_due && idle) begin
      st_next.xheat_pend = 1'b1;
    end

    // capture fresh values only in normal mode
    if (idle && i_meas.valid) begin
      st_next.out.rh = rh_sel;
      st_next.out.dew = i_meas.dew;
      st_next.out.amb = i_meas.amb;
      st_next.out.mix = i_meas.mix;
      st_next.out.rh_valid = i_tprobe || !(st_reg.warm_en && feat_ok);
    end

    // sequencer
    case (st_reg.state)
      shs_pkg::ST_IDLE: begin
        st_next.sec_cnt = 20'h0_0000;
        if (st_reg.purge_pend) begin
          st_next.state = shs_pkg::ST_PHEAT;
          st_next.purge_pend = purge_due; // set wins over clear
        end else if (st_reg.xheat_pend) begin
          st_next.state = shs_pkg::ST_XHEAT;
          st_next.xheat_pend = xheat_due && idle; // set wins over clear
        end
      end
      shs_pkg::ST_PHEAT: begin
        if (tick) begin
          st_next.sec_cnt = st_reg.sec_cnt + 20'h0_0001;
          if (st_reg.sec_cnt + 20'h0_0001 >= 20'(shs_pkg::PURGE_HEAT_S)) begin
            st_next.state = shs_pkg::ST_PCOOL;
            st_next.sec_cnt = 20'h0_0000;
          end
        end
      end
      shs_pkg::ST_PCOOL: begin
        if (tick) begin
          st_next.sec_cnt = st_reg.sec_cnt + 20'h0_0001;
          if (st_reg.sec_cnt + 20'h0_0001 >= 20'(shs_pkg::PURGE_COOL_S)) begin
            st_next.state = shs_pkg::ST_IDLE;
            st_next.sec_cnt = 20'h0_0000;
            st_next.intv_cnt = 20'h0_0000;
          end
        end
      end
      shs_pkg::ST_XHEAT: begin
        if (tick) begin
          st_next.sec_cnt = st_reg.sec_cnt + 20'h0_0001;
          if (st_reg.sec_cnt + 20'h0_0001 >= {4'h0, st_reg.xdur}) begin
            st_next.state = shs_pkg::ST_XCOOL;
            st_next.sec_cnt = 20'h0_0000;
          end
        end
      end
      shs_pkg::ST_XCOOL: begin
        if (tick) begin
          st_next.sec_cnt = st_reg.sec_cnt + 20'h0_0001;
          if (st_reg.sec_cnt + 20'h0_0001 >= 20'(shs_pkg::XCOOL_S)) begin
            st_next.state = shs_pkg::ST_IDLE;
            st_next.sec_cnt = 20'h0_0000;
          end
        end
      end
      default: begin
        st_next.state = shs_pkg::ST_IDLE;
        st_next.sec_cnt = 20'h0_0000;
      end
    endcase

    // losing the composite sensor aborts any cycle at once
    if (!feat_ok) begin
      st_next.state = shs_pkg::ST_IDLE;
      st_next.purge_pend = 1'b0;
      st_next.xheat_pend = 1'b0;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // stored purge settings are loaded while reset is held, so a reset
  // with startup purge stored starts a purge (manual purge path)
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.state <= shs_pkg::ST_IDLE;
      st_reg.su_en <= i_nv_startup;
      st_reg.iv_en <= i_nv_interval;
      st_reg.period <= shs_pkg::PERIOD_RST;
      st_reg.ptemp <= shs_pkg::PURGE_TEMP_RST;
      st_reg.xtemp <= shs_pkg::XHEAT_TEMP_RST;
      st_reg.xdur <= shs_pkg::XHEAT_DUR_RST;
      st_reg.xlim <= shs_pkg::XHEAT_LIMIT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // heater drive follows the registered state, the probe heater also gated by i_composite directly
  always_comb begin
    o_heat.probe_on = st_reg.warm_en && feat_ok;
    o_heat.probe_boost = o_heat.probe_on && (st_reg.out.rh >= shs_pkg::WARM_LIMIT);
    o_heat.sens_on = 1'b0;
    o_heat.sens_setpt = 16'h0000;
    if (st_reg.state == shs_pkg::ST_PHEAT) begin
      o_heat.sens_on = 1'b1;
      o_heat.sens_setpt = st_reg.ptemp;
    end else if (st_reg.state == shs_pkg::ST_XHEAT) begin
      o_heat.sens_on = 1'b1;
      o_heat.sens_setpt = st_reg.xtemp;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_out = st_reg.out;
  assign o_frozen = !idle;
  assign o_nv_startup = st_reg.su_en;
  assign o_nv_interval = st_reg.iv_en;
  assign o_dbg_unused_never = st_reg;

endmodule // shs_heat_seq

// ===== shs_heat_seq_properties.sv
// Purpose: port-level checks of the heating sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: cycle lengths scale with P_TICK_CYCLES
`timescale 1ns/100ps
module shs_heat_seq_properties #(
  parameter int P_TICK_CYCLES = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register port
  input wire shs_pkg::shs_bus_type i_bus,
  input wire logic [31:0] o_rdata,
  // fit and stored settings
  input wire logic i_composite,
  input wire logic i_tprobe,
  input wire logic i_nv_startup,
  // front end and outputs
  input wire shs_pkg::shs_meas_type i_meas,
  input wire shs_pkg::shs_heat_type o_heat,
  input wire shs_pkg::shs_out_type o_out,
  input wire logic o_frozen
);
  localparam int BOOT_WIN = 10 * P_TICK_CYCLES;
  localparam int CYC_MAX = (shs_pkg::PURGE_TOTAL_S + 2) * P_TICK_CYCLES;
  logic [15:0] frz_cnt_reg;

  // length of the running cycle; a stuck timer shows up as an endless hold
  always_ff @(posedge i_mclk) begin
    if (i_rst || !o_frozen)
      frz_cnt_reg <= 16'h0000;
    else
      frz_cnt_reg <= frz_cnt_reg + 16'h0001;
  end

  function automatic logic [15:0] rh_of(logic signed [15:0] amb, logic signed [15:0] dew);
    int x;
    x = 10000 - 5 * (int'(amb) - int'(dew));
    return (x < 0) ? 16'h0000 : (x > 10000) ? 16'h2710 : 16'(x);
  endfunction

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_boot;
    $fell(i_rst) && i_composite && i_nv_startup;
  endsequence
  sequence s_idle_sample;
    i_meas.valid && !o_frozen;
  endsequence

  heat_in_cycle_a: assert property (o_heat.sens_on |-> o_frozen)
    else $error("sensor heater on outside a cycle");
  out_hold_a: assert property (o_frozen |=> $stable(o_out))
    else $error("outputs moved during a cycle");
  rh_cut_a: assert property (s_idle_sample ##0 (o_heat.probe_on && i_composite && !i_tprobe)
    |=> !o_out.rh_valid && o_out.rh == 16'h0000)
    else $error("humidity shown while warmed without probe");
  rh_calc_a: assert property (s_idle_sample ##0 i_tprobe
    |=> o_out.rh == rh_of($past(i_meas.amb), $past(i_meas.dew)) && o_out.dew == $past(i_meas.dew))
    else $error("humidity not worked from dew point and ambient");
  rh_pass_a: assert property (s_idle_sample ##0 (!i_tprobe && !o_heat.probe_on)
    |=> o_out.rh == $past(i_meas.rh) && o_out.rh_valid)
    else $error("measured humidity not passed on");
  probe_boost_a: assert property (o_heat.probe_boost |-> o_heat.probe_on
    && o_out.rh >= shs_pkg::WARM_LIMIT)
    else $error("probe boost below the humidity limit");
  bare_sensor_a: assert property (!i_composite |=> !o_heat.probe_on && !o_heat.sens_on)
    else $error("heating without composite sensor");
  startup_purge_a: assert property (s_boot |-> ##[1:BOOT_WIN] o_frozen)
    else $error("startup purge late");
  cycle_bound_a: assert property (int'(frz_cnt_reg) <= CYC_MAX)
    else $error("cycle held too long");
  rdata_idle_a: assert property (!(i_bus.rd && !i_bus.addr[3]) |=> o_rdata == 32'h0000_0000)
    else $error("read data outside a read answer");
endmodule // shs_heat_seq_properties

bind shs_heat_seq shs_heat_seq_properties #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_props (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_composite(i_composite), .i_tprobe(i_tprobe), .i_nv_startup(i_nv_startup),
  .i_meas(i_meas), .o_heat(o_heat), .o_out(o_out), .o_frozen(o_frozen));

// ===== shs_front_end_model.sv
// Purpose: behavioural sensor front end facing the heating sequencer
// Assumes: one sample every eight clocks
// Notes: a heated sensor reads dry; fields between samples carry noise
`timescale 1ns/100ps
module shs_front_end_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // heater drive and scene from the bench
  input wire shs_pkg::shs_heat_type i_heat,
  input wire logic [15:0] i_scene_rh,
  input wire logic signed [15:0] i_scene_dew,
  input wire logic signed [15:0] i_scene_amb,
  // samples towards the sequencer
  output shs_pkg::shs_meas_type o_meas
);
  logic [2:0] div_reg;
  // idle fields toggle, so a design that reads them off-sample is caught
  always_ff @(posedge i_mclk) begin
    div_reg <= i_rst ? 3'h0 : div_reg + 3'h1;
    if (i_rst) begin
      o_meas <= '0;
    end else if (div_reg == 3'h7) begin
      o_meas.valid <= 1'b1;
      o_meas.rh <= i_heat.sens_on ? 16'h07D0 : i_scene_rh;
      o_meas.dew <= i_scene_dew;
      o_meas.amb <= i_scene_amb;
      o_meas.mix <= i_scene_rh ^ 16'h00FF;
    end else begin
      o_meas <= {1'b0, ~o_meas[63:0]};
    end
  end
endmodule // shs_front_end_model

// ===== testbench.sv
// Purpose: self-checking bench of the heating sequencer
// Assumes: a tick of 4 clocks stands in for one second
// Notes: interval purge periods are too long to run here
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  localparam int P = 4;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_composite = 1'b1;
  logic i_tprobe = 1'b0;
  logic i_nv_startup = 1'b0;
  logic i_nv_interval = 1'b1;
  shs_pkg::shs_bus_type i_bus = '0;
  shs_pkg::shs_meas_type i_meas;
  shs_pkg::shs_heat_type o_heat;
  shs_pkg::shs_out_type o_out;
  logic [31:0] o_rdata;
  logic o_frozen;
  logic o_nv_startup;
  logic o_nv_interval;
  logic [15:0] sc_rh = 16'h0FA0;
  logic signed [15:0] sc_dew = '0;
  logic signed [15:0] sc_amb = '0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 24949;
  int n, hot, d, a, r, m;
  logic [15:0] sp, hr, xt;
  logic [31:0] v, e;

  shs_heat_seq #(.P_TICK_CYCLES(P)) u_shs_heat_seq (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_bus(i_bus), .o_dbg_unused_never(), .o_rdata(o_rdata),
    .i_composite(i_composite), .i_tprobe(i_tprobe), .i_nv_startup(i_nv_startup),
    .i_nv_interval(i_nv_interval), .o_nv_startup(o_nv_startup), .o_nv_interval(o_nv_interval),
    .i_meas(i_meas), .o_heat(o_heat), .o_out(o_out), .o_frozen(o_frozen));
  shs_front_end_model u_shs_front_end_model (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_heat(o_heat), .i_scene_rh(sc_rh),
    .i_scene_dew(sc_dew), .i_scene_amb(sc_amb), .o_meas(i_meas));

  // ******************************************************************
  // clock, watchdog and helpers
  // ******************************************************************
  always #2.5 i_mclk = ~i_mclk;

  // the longest path is one purge plus a few short cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 8000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
    @(posedge i_mclk);
    i_bus <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    i_bus <= '0;
  endtask

  task automatic rd_chk(input logic [3:0] ad, input logic [31:0] ex);
    @(posedge i_mclk);
    i_bus <= '{addr: ad, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    i_bus <= '0;
    #1;
    `CHK("read data", ex, o_rdata)
  endtask

  // waits for a cycle, then times it and keeps the value held at its start
  task automatic run_cycle();
    n = 0;
    hot = 0;
    sp = 16'h0000;
    while (o_frozen !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    `CHK("cycle start", 1'b1, o_frozen)
    hr = o_out.rh;
    n = 0;
    while (o_frozen === 1'b1 && n < 3000) begin
      if (o_heat.sens_on === 1'b1) begin
        hot++;
        sp = o_heat.sens_setpt;
      end
      @(posedge i_mclk);
      #1;
      n++;
    end
    `CHK("end of hold", hr, o_out.rh)
  endtask

  // changes the scene once the cycle is under way
  task automatic cycle_then(input logic [15:0] nxt);
    fork
      run_cycle();
      begin
        wait (o_frozen === 1'b1);
        @(posedge i_mclk);
        sc_rh <= nxt;
      end
    join
  endtask

  function automatic logic [15:0] rh_of(int am, int dw);
    int x;
    x = 10000 - 5 * (am - dw);
    return (x < 0) ? 16'h0000 : (x > 10000) ? 16'h2710 : 16'(x);
  endfunction

  function automatic logic [31:0] clamp(logic [31:0] x);
    return (x < 32'(shs_pkg::PERIOD_MIN)) ? 32'(shs_pkg::PERIOD_MIN) :
      (x > 32'(shs_pkg::PERIOD_MAX)) ? 32'(shs_pkg::PERIOD_MAX) : x;
  endfunction

  function automatic logic near(int x, int y);
    return x >= y - P && x <= y + P;
  endfunction

  // ******************************************************************
  // main sequence
  // ******************************************************************
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    wr(4'hB, 32'hFFFF_FFFF);
    rd_chk(4'hB, 32'h0000_0000);
    rd_chk(shs_pkg::REG_CTRL, 32'h0000_0000);
    rd_chk(shs_pkg::REG_PURGE_CFG, 32'h0000_0002);
    rd_chk(shs_pkg::REG_PURGE_PERIOD, 32'(shs_pkg::PERIOD_RST));
    rd_chk(shs_pkg::REG_PURGE_TEMP, 32'(shs_pkg::PURGE_TEMP_RST));
    rd_chk(shs_pkg::REG_XHEAT_TEMP, 32'(shs_pkg::XHEAT_TEMP_RST));
    rd_chk(shs_pkg::REG_XHEAT_DUR, 32'(shs_pkg::XHEAT_DUR_RST));
    rd_chk(shs_pkg::REG_XHEAT_LIMIT, 32'(shs_pkg::XHEAT_LIMIT_RST));
    wr(shs_pkg::REG_PURGE_CFG, 32'h0000_0000);
    #1;
    `CHK("interval purge", 1'b0, o_nv_interval)
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 32'h0000_0000 : (k == 1) ? 32'hFFFF_FFFF : {$random(seed)} % 900000;
      wr(shs_pkg::REG_PURGE_PERIOD, v);
      rd_chk(shs_pkg::REG_PURGE_PERIOD, clamp(v));
    end
    wr(shs_pkg::REG_XHEAT_DUR, 32'h0000_0000);
    rd_chk(shs_pkg::REG_XHEAT_DUR, 32'h0000_0001);
    xt = 16'({$random(seed)} % 20000);
    wr(shs_pkg::REG_XHEAT_TEMP, 32'(xt));
    rd_chk(shs_pkg::REG_XHEAT_TEMP, 32'(xt));
    // output path: probe with ambient, plain, warmed without probe
    for (int k = 0; k < 6; k++) begin
      m = k % 3;
      d = $random(seed) % 2000;
      a = d + {$random(seed)} % 1000;
      r = {$random(seed)} % 9000;
      wr(shs_pkg::REG_CTRL, (m == 1) ? 32'h0000_0000 : 32'h0000_0001);
      @(posedge i_mclk);
      i_tprobe <= (m == 0);
      sc_dew <= 16'(d);
      sc_amb <= 16'(a);
      sc_rh <= 16'(r);
      repeat (20) @(posedge i_mclk);
      #1;
      e = (m == 0) ? 32'(rh_of(a, d)) : (m == 1) ? r : 0;
      `CHK("humidity", e[15:0], o_out.rh)
      `CHK("humidity valid", m != 2, o_out.rh_valid)
      `CHK("dew point", 16'(d), o_out.dew)
      `CHK("mixing ratio", 16'(r) ^ 16'h00FF, o_out.mix)
      `CHK("probe heater", m != 1, o_heat.probe_on)
      `CHK("probe boost", m == 0 && e >= 8000, o_heat.probe_boost)
    end
    // extra heating: one count under the limit, then at it, twice
    @(posedge i_mclk);
    i_tprobe <= 1'b0;
    sc_rh <= 16'h251B;
    wr(shs_pkg::REG_XHEAT_DUR, 32'h0000_0003);
    wr(shs_pkg::REG_CTRL, 32'h0000_0002);
    repeat (30) @(posedge i_mclk);
    #1;
    `CHK("idle below limit", 1'b0, o_frozen)
    @(posedge i_mclk);
    sc_rh <= 16'h251C;
    for (int k = 0; k < 2; k++) begin
      cycle_then((k == 0) ? 16'h251C : 16'h0FA0);
      `CHK("xheat length", 1'b1, near(n, (3 + shs_pkg::XCOOL_S) * P))
      `CHK("xheat on time", 1'b1, near(hot, 3 * P))
      `CHK("xheat setpoint", xt, sp)
      `CHK("held humidity", 16'h251C, hr)
    end
    // manual purge: startup on, reset, extra heating asked for meanwhile
    wr(shs_pkg::REG_PURGE_CFG, 32'h0000_0001);
    #1;
    `CHK("stored startup", 1'b1, o_nv_startup)
    @(posedge i_mclk);
    i_nv_startup <= o_nv_startup;
    i_nv_interval <= o_nv_interval;
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    wr(shs_pkg::REG_CTRL, 32'h0000_0002);
    cycle_then(16'h2580);
    `CHK("purge length", 1'b1, near(n, shs_pkg::PURGE_TOTAL_S * P))
    `CHK("purge heating", 1'b1, near(hot, shs_pkg::PURGE_HEAT_S * P))
    `CHK("purge setpoint", shs_pkg::PURGE_TEMP_RST, sp)
    run_cycle();
    `CHK("queued xheat", shs_pkg::XHEAT_TEMP_RST, sp)
    wr(shs_pkg::REG_PURGE_CFG, 32'h0000_0000);
    #1;
    `CHK("startup off", 1'b0, o_nv_startup)
    // plain sensor fitted: nothing may heat
    wr(shs_pkg::REG_CTRL, 32'h0000_0003);
    @(posedge i_mclk);
    i_composite <= 1'b0;
    repeat (40) @(posedge i_mclk);
    #1;
    `CHK("no cycle", 1'b0, o_frozen)
    `CHK("no probe heat", 1'b0, o_heat.probe_on)
    tally_and_finish();
  end
endmodule // testbench
